// ### rtl/tcr_defines.svh
// offsets, field positions, widths and reset values of the result and config bank
// assumes inclusion by bare name from the design
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TCR_ADR_START_OFFSET 4'h5
`define TCR_ADR_FIFO_THRESH 4'h6
`define TCR_ADR_PLL_TIMER 4'h7
`define TCR_ADR_FIRST_RESULT 4'h8
`define TCR_ADR_SECOND_RESULT 4'h9
`define TCR_ADR_FIRST_INTERVAL 4'hA
`define TCR_ADR_BUS_WIDTH 4'hE
// ----------------------------------------
// widths
// ----------------------------------------
`define TCR_DATA_W 28
`define TCR_HALF_W 16
`define TCR_HIGH_W 12
`define TCR_OFFSET_W 18
`define TCR_TIME_W 23
`define TCR_INTERVAL_W 17
// ----------------------------------------
// start offset and reset trigger fields
// ----------------------------------------
`define TCR_PRI_OFFSET_LSB 0
`define TCR_PRI_OFFSET_MSB 17
`define TCR_HOLD_STOPS_BIT 21
`define TCR_BLOCK_BEGIN_BIT 22
`define TCR_FULL_CALC_BIT 23
`define TCR_PART_CALC_BIT 24
`define TCR_FULL_OUTEN_BIT 25
`define TCR_PART_OUTEN_BIT 26
`define TCR_REARM_BIT 27
// ----------------------------------------
// threshold and routing fields
// ----------------------------------------
`define TCR_FILL_LSB 0
`define TCR_FILL_MSB 7
`define TCR_SEC_OFFSET_LSB 8
`define TCR_SEC_OFFSET_MSB 25
`define TCR_ROUTING_BIT 26
`define TCR_POWER_BIT 27
// ----------------------------------------
// pll and timer fields
// ----------------------------------------
`define TCR_FAST_DIV_LSB 0
`define TCR_FAST_DIV_MSB 7
`define TCR_REF_DIV_LSB 8
`define TCR_REF_DIV_MSB 10
`define TCR_RES_REG_BIT 11
`define TCR_PHASE_INV_BIT 12
`define TCR_LOOP_OPEN_BIT 13
`define TCR_TIMER_LSB 15
`define TCR_TIMER_MSB 27
// ----------------------------------------
// bus width and misc
// ----------------------------------------
`define TCR_HALF_BUS_BIT 4
`define TCR_REARM_ONE 8'h01
`define TCR_CFG_RESET 28'h0000000
`define TCR_BUF_DEPTH 2
`endif

// ### rtl/tcr_pkg.sv
// types of the result and config bank
// assumes tcr_defines.svh is on the include path
package tcr_pkg;
	typedef enum logic [1:0] {
		TCR_MODE_I = 2'b00,
		TCR_MODE_G = 2'b01,
		TCR_MODE_R = 2'b10,
		TCR_MODE_M = 2'b11
	} tcr_mode_t;
	typedef enum logic {
		TCR_HALF_LOW = 1'b0,
		TCR_HALF_HIGH = 1'b1
	} tcr_half_t;
endpackage

// ### rtl/tcr_config_result_regs.sv
// configuration and result register bank of an eight channel time converter
// assumes an asynchronous host bus (chip select, read and write strobes, active low)
// and a measurement core on the same clock delivering two result streams
`timescale 1ns/1ps
`include "tcr_defines.svh"
module tcr_config_result_regs (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic [3:0] bus_addr,
	input wire logic [`TCR_DATA_W-1:0] bus_data_in,
	output logic [`TCR_DATA_W-1:0] bus_data_out,
	output logic bus_data_oe,
	input wire logic calc_trigger_pin,
	input wire logic output_enable_pin_n,
	input wire logic [1:0] mode_sel,
	input wire logic quiet_mode,
	input wire logic [7:0] rearm_period_field,
	input wire logic begin_pulse,
	input wire logic [`TCR_INTERVAL_W-1:0] first_rearm_interval,
	input wire logic [1:0] queue_valid,
	output logic [1:0] queue_ready,
	input wire logic [`TCR_TIME_W-1:0] queue0_time,
	input wire logic [`TCR_TIME_W-1:0] queue1_time,
	input wire logic [1:0] queue_edge,
	input wire logic [7:0] queue0_begin_num,
	input wire logic [7:0] queue1_begin_num,
	input wire logic [1:0] queue0_channel,
	input wire logic [1:0] queue1_channel,
	input wire logic [7:0] queue0_level,
	input wire logic [7:0] queue1_level,
	output logic [1:0] fill_level_flag,
	output logic stop_inputs_enable,
	output logic begin_input_enable,
	output logic full_clear,
	output logic part_clear,
	output logic external_rearm,
	output logic diff_input_routing,
	output logic diff_input_power,
	output logic [7:0] pll_fast_divider,
	output logic [2:0] pll_ref_divider,
	output logic resolution_regulation_on,
	output logic pll_phase_invert,
	output logic pll_loop_open,
	output logic [12:0] measure_window_timer,
	output logic half_width_bus_select
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [`TCR_DATA_W-1:0] pack_result(
		input tcr_pkg::tcr_mode_t mode,
		input logic [`TCR_TIME_W-1:0] t,
		input logic edge_bit,
		input logic [7:0] num,
		input logic [1:0] chan
	);
		logic [`TCR_DATA_W-1:0] w;
		w = '0;
		unique case (mode)
			tcr_pkg::TCR_MODE_I: w = {chan, num, edge_bit, t[16:0]};
			tcr_pkg::TCR_MODE_G: w = {5'h00, edge_bit, t[21:0]};
			tcr_pkg::TCR_MODE_R, tcr_pkg::TCR_MODE_M: w = {5'h00, t};
		endcase
		return w;
	endfunction

	function automatic logic [`TCR_TIME_W-1:0] add_offset(
		input logic [`TCR_TIME_W-1:0] t,
		input logic [`TCR_OFFSET_W-1:0] off
	);
		return t + {5'h00, off};
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] ctl_meta_r;
	logic [3:0] ctl_sync_r;
	logic [3:0] addr_meta_r;
	logic [3:0] addr_sync_r;
	logic [`TCR_DATA_W-1:0] din_meta_r;
	logic [`TCR_DATA_W-1:0] din_sync_r;
	logic [1:0] pin_meta_r;
	logic [1:0] pin_sync_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_meta_r <= 4'hF;
			ctl_sync_r <= 4'hF;
			addr_meta_r <= 4'h0;
			addr_sync_r <= 4'h0;
			din_meta_r <= '0;
			din_sync_r <= '0;
			pin_meta_r <= 2'h2;
			pin_sync_r <= 2'h2;
		end else begin
			ctl_meta_r <= {1'b1, bus_cs_n, bus_rd_n, bus_wr_n};
			ctl_sync_r <= ctl_meta_r;
			addr_meta_r <= bus_addr;
			addr_sync_r <= addr_meta_r;
			din_meta_r <= bus_data_in;
			din_sync_r <= din_meta_r;
			pin_meta_r <= {output_enable_pin_n, calc_trigger_pin};
			pin_sync_r <= pin_meta_r;
		end
	end

	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic calc_s;
	logic outen_n_s;
	assign cs_n_s = ctl_sync_r[2];
	assign rd_n_s = ctl_sync_r[1];
	assign wr_n_s = ctl_sync_r[0];
	assign calc_s = pin_sync_r[0];
	assign outen_n_s = pin_sync_r[1];

	// ----------------------------------------
	// strobe edges
	// ----------------------------------------
	logic rd_n_d_r;
	logic wr_n_d_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_n_d_r <= 1'b1;
			wr_n_d_r <= 1'b1;
		end else begin
			rd_n_d_r <= rd_n_s;
			wr_n_d_r <= wr_n_s;
		end
	end

	logic rd_begin;
	logic rd_end;
	logic wr_end;
	assign rd_begin = rd_d_fall(rd_n_d_r, rd_n_s) && !cs_n_s;
	assign rd_end = !rd_n_d_r && rd_n_s && !cs_n_s;
	assign wr_end = !wr_n_d_r && wr_n_s && !cs_n_s;

	function automatic logic rd_d_fall(input logic prev, input logic cur);
		return prev && !cur;
	endfunction

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [`TCR_DATA_W-1:0] start_offset_and_reset_triggers_r;
	logic [`TCR_DATA_W-1:0] fifo_threshold_and_input_routing_r;
	logic [`TCR_DATA_W-1:0] pll_and_timer_settings_r;
	logic [`TCR_DATA_W-1:0] bus_width_select_r;
	logic [`TCR_HALF_W-1:0] low_half_r;
	tcr_pkg::tcr_half_t wr_half_r;
	tcr_pkg::tcr_half_t rd_half_r;
	logic half_mode;
	assign half_mode = bus_width_select_r[`TCR_HALF_BUS_BIT];

	logic wr_commit;
	logic [`TCR_DATA_W-1:0] wr_word;
	// 16-bit mode: low half first, high half commits the word
	assign wr_commit = wr_end && (!half_mode || wr_half_r == tcr_pkg::TCR_HALF_HIGH);
	assign wr_word = half_mode ? {din_sync_r[`TCR_HIGH_W-1:0], low_half_r} : din_sync_r;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_half_r <= tcr_pkg::TCR_HALF_LOW;
			low_half_r <= '0;
		end else if (wr_end && half_mode) begin
			if (wr_half_r == tcr_pkg::TCR_HALF_LOW) begin
				low_half_r <= din_sync_r[`TCR_HALF_W-1:0];
				wr_half_r <= tcr_pkg::TCR_HALF_HIGH;
			end else begin
				wr_half_r <= tcr_pkg::TCR_HALF_LOW;
			end
		end else if (!half_mode) begin
			wr_half_r <= tcr_pkg::TCR_HALF_LOW;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			start_offset_and_reset_triggers_r <= `TCR_CFG_RESET;
			fifo_threshold_and_input_routing_r <= `TCR_CFG_RESET;
			pll_and_timer_settings_r <= `TCR_CFG_RESET;
			bus_width_select_r <= `TCR_CFG_RESET;
		end else if (wr_commit) begin
			unique case (addr_sync_r)
				`TCR_ADR_START_OFFSET: start_offset_and_reset_triggers_r <= wr_word;
				`TCR_ADR_FIFO_THRESH: fifo_threshold_and_input_routing_r <= wr_word;
				`TCR_ADR_PLL_TIMER: pll_and_timer_settings_r <= wr_word;
				`TCR_ADR_BUS_WIDTH: bus_width_select_r <= wr_word;
				default: ;
			endcase
		end
	end

	tcr_pkg::tcr_mode_t mode;
	assign mode = tcr_pkg::tcr_mode_t'(mode_sel);
	logic [`TCR_OFFSET_W-1:0] pri_offset;
	logic [`TCR_OFFSET_W-1:0] sec_offset;
	logic [7:0] fill_thresh;
	assign pri_offset = start_offset_and_reset_triggers_r[`TCR_PRI_OFFSET_MSB:`TCR_PRI_OFFSET_LSB];
	assign sec_offset = fifo_threshold_and_input_routing_r[`TCR_SEC_OFFSET_MSB:`TCR_SEC_OFFSET_LSB];
	assign fill_thresh = fifo_threshold_and_input_routing_r[`TCR_FILL_MSB:`TCR_FILL_LSB];

	// ----------------------------------------
	// result buffers, two entries per queue
	// ----------------------------------------
	logic [`TCR_DATA_W-1:0] buf_mem_r [0:1][0:`TCR_BUF_DEPTH-1];
	logic [1:0] buf_wp_r;
	logic [1:0] buf_rp_r;
	logic [1:0] buf_cnt_r [0:1];
	logic [1:0] pop_req;
	logic [1:0] push;
	logic [1:0] pop;
	logic [`TCR_DATA_W-1:0] in_word [0:1];

	always_comb begin
		in_word[0] = pack_result(mode, add_offset(queue0_time, pri_offset), queue_edge[0],
			queue0_begin_num, queue0_channel);
		// second queue uses the second offset in G mode
		in_word[1] = pack_result(mode, add_offset(queue1_time,
			(mode == tcr_pkg::TCR_MODE_G) ? sec_offset : pri_offset),
			queue_edge[1], queue1_begin_num, queue1_channel);
	end

	always_comb begin
		for (int q = 0; q < 2; q++) begin
			push[q] = queue_valid[q] && queue_ready[q];
			pop[q] = pop_req[q] && (buf_cnt_r[q] != 2'd0);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			buf_wp_r <= 2'b00;
			buf_rp_r <= 2'b00;
			queue_ready <= 2'b11;
			for (int q = 0; q < 2; q++) begin
				buf_cnt_r[q] <= 2'd0;
				buf_mem_r[q][0] <= '0;
				buf_mem_r[q][1] <= '0;
			end
		end else begin
			for (int q = 0; q < 2; q++) begin
				if (push[q]) begin
					buf_mem_r[q][buf_wp_r[q]] <= in_word[q];
					buf_wp_r[q] <= !buf_wp_r[q];
				end
				if (pop[q]) begin
					buf_rp_r[q] <= !buf_rp_r[q];
				end
				if (push[q] && !pop[q]) begin
					buf_cnt_r[q] <= buf_cnt_r[q] + 2'd1;
					queue_ready[q] <= (buf_cnt_r[q] == 2'd0);
				end else if (pop[q] && !push[q]) begin
					buf_cnt_r[q] <= buf_cnt_r[q] - 2'd1;
					queue_ready[q] <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [`TCR_DATA_W-1:0] rd_word;
	always_comb begin
		rd_word = '0;
		unique case (addr_sync_r)
			`TCR_ADR_START_OFFSET: rd_word = start_offset_and_reset_triggers_r;
			`TCR_ADR_FIFO_THRESH: rd_word = fifo_threshold_and_input_routing_r ^ 28'h00000FF;
			`TCR_ADR_PLL_TIMER: rd_word = pll_and_timer_settings_r;
			`TCR_ADR_BUS_WIDTH: rd_word = bus_width_select_r;
			`TCR_ADR_FIRST_RESULT: begin
				if (buf_cnt_r[0] != 2'd0) begin
					rd_word = buf_mem_r[0][buf_rp_r[0]];
				end
			end
			`TCR_ADR_SECOND_RESULT: begin
				if (buf_cnt_r[1] != 2'd0) begin
					rd_word = buf_mem_r[1][buf_rp_r[1]];
				end
			end
			`TCR_ADR_FIRST_INTERVAL: begin
				if (mode == tcr_pkg::TCR_MODE_I) begin
					rd_word = {11'h000, first_rearm_interval};
				end
			end
			default: rd_word = '0;
		endcase
	end

	always_comb begin
		pop_req = 2'b00;
		if (rd_end && (!half_mode || rd_half_r == tcr_pkg::TCR_HALF_HIGH)) begin
			pop_req[0] = (addr_sync_r == `TCR_ADR_FIRST_RESULT);
			pop_req[1] = (addr_sync_r == `TCR_ADR_SECOND_RESULT);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bus_data_out <= '0;
			rd_half_r <= tcr_pkg::TCR_HALF_LOW;
		end else begin
			if (rd_begin) begin
				if (!half_mode) begin
					bus_data_out <= rd_word;
				end else if (rd_half_r == tcr_pkg::TCR_HALF_LOW) begin
					bus_data_out <= {12'h000, rd_word[`TCR_HALF_W-1:0]};
				end else begin
					bus_data_out <= {16'h0000, rd_word[`TCR_DATA_W-1:`TCR_HALF_W]};
				end
			end
			if (!half_mode) begin
				rd_half_r <= tcr_pkg::TCR_HALF_LOW;
			end else if (rd_end) begin
				rd_half_r <= (rd_half_r == tcr_pkg::TCR_HALF_LOW) ?
					tcr_pkg::TCR_HALF_HIGH : tcr_pkg::TCR_HALF_LOW;
			end
		end
	end

	// output enable pin gates the bus only while no clear trigger claims it
	logic outen_as_trigger;
	assign outen_as_trigger = start_offset_and_reset_triggers_r[`TCR_FULL_OUTEN_BIT] ||
		start_offset_and_reset_triggers_r[`TCR_PART_OUTEN_BIT];
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bus_data_oe <= 1'b0;
		end else begin
			bus_data_oe <= !cs_n_s && !rd_n_s && (outen_as_trigger || !outen_n_s);
		end
	end

	// ----------------------------------------
	// clears, start gating and rearm
	// ----------------------------------------
	logic calc_ok;
	logic full_nxt;
	logic part_nxt;
	assign calc_ok = calc_s && !quiet_mode;
	assign full_nxt = (start_offset_and_reset_triggers_r[`TCR_FULL_CALC_BIT] && calc_ok) ||
		(start_offset_and_reset_triggers_r[`TCR_FULL_OUTEN_BIT] && !outen_n_s);
	assign part_nxt = (start_offset_and_reset_triggers_r[`TCR_PART_CALC_BIT] && calc_ok) ||
		(start_offset_and_reset_triggers_r[`TCR_PART_OUTEN_BIT] && !outen_n_s);

	logic begin_seen_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			begin_seen_r <= 1'b0;
		end else if (begin_pulse) begin
			begin_seen_r <= 1'b1;
		end else if (full_nxt || part_nxt) begin
			begin_seen_r <= 1'b0;
		end
	end

	logic seen_nxt;
	assign seen_nxt = begin_seen_r || begin_pulse;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			full_clear <= 1'b0;
			part_clear <= 1'b0;
			stop_inputs_enable <= 1'b1;
			begin_input_enable <= 1'b1;
			external_rearm <= 1'b0;
			fill_level_flag <= 2'b00;
		end else begin
			full_clear <= full_nxt;
			part_clear <= part_nxt && !full_nxt;
			stop_inputs_enable <= !(start_offset_and_reset_triggers_r[`TCR_HOLD_STOPS_BIT] &&
				!seen_nxt);
			begin_input_enable <= !(start_offset_and_reset_triggers_r[`TCR_BLOCK_BEGIN_BIT] &&
				seen_nxt && mode != tcr_pkg::TCR_MODE_I);
			external_rearm <= start_offset_and_reset_triggers_r[`TCR_REARM_BIT] &&
				rearm_period_field == `TCR_REARM_ONE && mode != tcr_pkg::TCR_MODE_M;
			fill_level_flag[0] <= mode != tcr_pkg::TCR_MODE_M && queue0_level >= fill_thresh;
			fill_level_flag[1] <= mode != tcr_pkg::TCR_MODE_M && queue1_level >= fill_thresh;
		end
	end

	// ----------------------------------------
	// configuration outputs
	// ----------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			diff_input_routing <= 1'b0;
			diff_input_power <= 1'b0;
			pll_fast_divider <= 8'h00;
			pll_ref_divider <= 3'h0;
			resolution_regulation_on <= 1'b0;
			pll_phase_invert <= 1'b0;
			pll_loop_open <= 1'b0;
			measure_window_timer <= 13'h0000;
			half_width_bus_select <= 1'b0;
		end else begin
			diff_input_routing <= fifo_threshold_and_input_routing_r[`TCR_ROUTING_BIT] &&
				mode == tcr_pkg::TCR_MODE_I;
			diff_input_power <= fifo_threshold_and_input_routing_r[`TCR_POWER_BIT];
			pll_fast_divider <= pll_and_timer_settings_r[`TCR_FAST_DIV_MSB:`TCR_FAST_DIV_LSB];
			pll_ref_divider <= pll_and_timer_settings_r[`TCR_REF_DIV_MSB:`TCR_REF_DIV_LSB];
			resolution_regulation_on <= pll_and_timer_settings_r[`TCR_RES_REG_BIT];
			pll_phase_invert <= pll_and_timer_settings_r[`TCR_PHASE_INV_BIT];
			pll_loop_open <= pll_and_timer_settings_r[`TCR_LOOP_OPEN_BIT];
			measure_window_timer <= pll_and_timer_settings_r[`TCR_TIMER_MSB:`TCR_TIMER_LSB];
			half_width_bus_select <= half_mode;
		end
	end
endmodule

// ### tb/tcr_chk.sv
// port assertions of the config and result bank
// assumes it is bound onto tcr_config_result_regs
`timescale 1ns/1ps
module tcr_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_data_oe,
	input wire logic calc_trigger_pin,
	input wire logic output_enable_pin_n,
	input wire logic [1:0] mode_sel,
	input wire logic quiet_mode,
	input wire logic [7:0] rearm_period_field,
	input wire logic [1:0] fill_level_flag,
	input wire logic begin_input_enable,
	input wire logic full_clear,
	input wire logic part_clear,
	input wire logic external_rearm,
	input wire logic diff_input_routing
);
	// ----
	// properties
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_pins_idle;
		(!calc_trigger_pin && output_enable_pin_n) [*5];
	endsequence
	sequence s_quiet_idle;
		(quiet_mode && output_enable_pin_n) [*5];
	endsequence
	sequence s_bus_idle;
		(bus_cs_n || bus_rd_n) [*5];
	endsequence
	a_rearm_cause: assert property (
		external_rearm |-> $past(rearm_period_field) == 8'h01 && $past(mode_sel) != 2'h3)
		else $error("rearm without its cause");
	a_route_imode: assert property (diff_input_routing |-> $past(mode_sel) == 2'h0)
		else $error("routing outside I mode");
	a_begin_imode: assert property (!begin_input_enable |-> $past(mode_sel) != 2'h0)
		else $error("start blocked in I mode");
	a_fill_mmode: assert property (mode_sel == 2'h3 |=> fill_level_flag == 2'h0)
		else $error("fill flag in M mode");
	a_clear_excl: assert property (part_clear |-> !full_clear)
		else $error("both clears at once");
	a_pins_noclr: assert property (s_pins_idle |=> !full_clear && !part_clear)
		else $error("clear with pins idle");
	a_quiet_noclr: assert property (s_quiet_idle |=> !full_clear && !part_clear)
		else $error("clear in quiet mode");
	a_oe_idle: assert property (s_bus_idle |=> !bus_data_oe)
		else $error("data driven with no read");
endmodule
bind tcr_config_result_regs tcr_chk tcr_chk_i (.clock, .sys_rst, .bus_cs_n, .bus_rd_n,
	.bus_data_oe, .calc_trigger_pin, .output_enable_pin_n, .mode_sel, .quiet_mode,
	.rearm_period_field, .fill_level_flag, .begin_input_enable, .full_clear, .part_clear,
	.external_rearm, .diff_input_routing);

// ### tb/tcr_core_model.sv
// measurement core model feeding the two result streams
// assumes the bench calls push and the bank takes a word on valid and ready
`timescale 1ns/1ps
module tcr_core_model (
	input wire logic clock,
	input wire logic [1:0] queue_ready,
	output logic [1:0] queue_valid,
	output logic [22:0] queue0_time,
	output logic [22:0] queue1_time,
	output logic [1:0] queue_edge,
	output logic [7:0] queue0_begin_num,
	output logic [7:0] queue1_begin_num,
	output logic [1:0] queue0_channel,
	output logic [1:0] queue1_channel
);
	initial begin
		queue_valid = 2'h0;
		{queue0_time, queue1_time, queue_edge} = 48'h5A5A5A5A5A5A;
		{queue0_begin_num, queue1_begin_num, queue0_channel, queue1_channel} = 20'hA5A5A;
	end
	// ----
	// push one word, hold it until taken
	// ----
	task automatic push(input logic q, input logic [22:0] t, input logic e,
		input logic [7:0] n, input logic [1:0] c);
		@(posedge clock);
		if (q) begin
			queue1_time <= t;
			queue1_begin_num <= n;
			queue1_channel <= c;
		end else begin
			queue0_time <= t;
			queue0_begin_num <= n;
			queue0_channel <= c;
		end
		queue_edge[q] <= e;
		queue_valid[q] <= 1'b1;
		do
			@(posedge clock);
		while (queue_ready[q] !== 1'b1);
		queue_valid[q] <= 1'b0;
		// stale time and edge lines are inverted so a lost word cannot look right
		if (q)
			queue1_time <= ~t;
		else
			queue0_time <= ~t;
		queue_edge[q] <= ~e;
	endtask
endmodule

// ### tb/tcr_config_result_regs_tb_top.sv
// self checking bench of the config and result bank
// assumes the core model drives the streams and the checker is bound
`timescale 1ns/1ps
module tcr_config_result_regs_tb_top;
	localparam logic [27:0] PLL_V = 28'hD5A3B65;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic bus_cs_n = 1'b1, bus_rd_n = 1'b1, bus_wr_n = 1'b1, begin_pulse = 1'b0;
	logic calc_trigger_pin = 1'b0, output_enable_pin_n = 1'b0, quiet_mode = 1'b0;
	logic [3:0] bus_addr = 4'h0;
	logic [27:0] bus_data_in = 28'h0, bus_data_out;
	logic [1:0] mode_sel = 2'h0, queue_valid, queue_ready, queue_edge, fill_level_flag;
	logic [1:0] queue0_channel, queue1_channel;
	logic [16:0] first_rearm_interval = 17'h1ABCD;
	logic [22:0] queue0_time, queue1_time;
	logic [7:0] queue0_begin_num, queue1_begin_num, pll_fast_divider;
	logic [7:0] queue0_level = 8'h00, queue1_level = 8'h00, rearm_period_field = 8'h00;
	logic bus_data_oe, stop_inputs_enable, begin_input_enable, full_clear, part_clear;
	logic external_rearm, diff_input_routing, diff_input_power, resolution_regulation_on;
	logic pll_phase_invert, pll_loop_open, half_width_bus_select;
	logic [2:0] pll_ref_divider;
	logic [12:0] measure_window_timer;
	int num_errors = 0, n_compared = 0, cycles = 0;
	always #20 clock = ~clock;
	tcr_config_result_regs tcr_config_result_regs_i (.clock, .sys_rst, .bus_cs_n, .bus_rd_n,
		.bus_wr_n, .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe, .calc_trigger_pin,
		.output_enable_pin_n, .mode_sel, .quiet_mode, .rearm_period_field, .begin_pulse,
		.first_rearm_interval, .queue_valid, .queue_ready, .queue0_time, .queue1_time,
		.queue_edge, .queue0_begin_num, .queue1_begin_num, .queue0_channel, .queue1_channel,
		.queue0_level, .queue1_level, .fill_level_flag, .stop_inputs_enable,
		.begin_input_enable, .full_clear, .part_clear, .external_rearm, .diff_input_routing,
		.diff_input_power, .pll_fast_divider, .pll_ref_divider, .resolution_regulation_on,
		.pll_phase_invert, .pll_loop_open, .measure_window_timer, .half_width_bus_select);
	tcr_core_model tcr_core_model_i (.clock, .queue_ready, .queue_valid, .queue0_time,
		.queue1_time, .queue_edge, .queue0_begin_num, .queue1_begin_num, .queue0_channel,
		.queue1_channel);
	// ----
	// tasks
	// ----
	task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic [27:0] d, input logic rd);
		@(posedge clock);
		bus_cs_n <= 1'b0;
		bus_addr <= a;
		bus_data_in <= d;
		bus_rd_n <= !rd;
		bus_wr_n <= rd;
		repeat (6) @(posedge clock);
		bus_rd_n <= 1'b1;
		bus_wr_n <= 1'b1;
		repeat (4) @(posedge clock);
		bus_cs_n <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [27:0] d);
		bus(a, d, 1'b0);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [27:0] exp);
		bus(a, 28'h0, 1'b1);
		cmp(bus_data_out, exp);
	endtask
	function automatic logic [27:0] pack(input logic [1:0] m, input logic [22:0] t,
		input logic e, input logic [7:0] n, input logic [1:0] c, input logic [17:0] off);
		logic [22:0] s;
		s = t + {5'h00, off};
		case (m)
			2'h0: pack = {c, n, e, s[16:0]};
			2'h1: pack = {5'h00, e, s[21:0]};
			default: pack = {5'h00, s};
		endcase
	endfunction
	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			num_errors++;
			finish_test();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		rd_chk(4'h5, 28'h0000000);
		rd_chk(4'h6, 28'h00000FF);
		rd_chk(4'h3, 28'h0000000);
		wr(4'h5, 28'h0000010);
		rd_chk(4'h5, 28'h0000010);
		wr(4'h6, 28'hC002002);
		rd_chk(4'h6, 28'hC0020FD);
		cmp({diff_input_power, diff_input_routing}, 2'h3);
		mode_sel <= 2'h1;
		queue0_level <= 8'h02;
		queue1_level <= 8'h01;
		repeat (4) @(posedge clock);
		cmp({diff_input_power, diff_input_routing, fill_level_flag}, 4'h9);
		mode_sel <= 2'h3;
		repeat (4) @(posedge clock);
		cmp(fill_level_flag, 2'h0);
		for (int m = 0; m < 4; m++) begin
			mode_sel <= 2'(m);
			tcr_core_model_i.push(1'b0, 23'h7FFFF0, 1'b1, 8'hA5, 2'h2);
			rd_chk(4'h8, pack(2'(m), 23'h7FFFF0, 1'b1, 8'hA5, 2'h2, 18'h10));
			tcr_core_model_i.push(1'b1, 23'h123456, 1'b0, 8'h3C, 2'h1);
			cmp(queue_ready, 2'h3);
			rd_chk(4'h9, pack(2'(m), 23'h123456, 1'b0, 8'h3C, 2'h1,
				m == 1 ? 18'h20 : 18'h10));
			rd_chk(4'hA, m == 0 ? 28'h001ABCD : 28'h0);
		end
		mode_sel <= 2'h2;
		fork
			for (int k = 1; k < 4; k++)
				tcr_core_model_i.push(1'b0, 23'(k), 1'b0, 8'h00, 2'h0);
		join_none
		repeat (20) @(posedge clock);
		cmp(queue_ready, 2'h2);
		for (int k = 1; k < 4; k++)
			rd_chk(4'h8, 28'(k + 16));
		rd_chk(4'h8, 28'h0);
		wr(4'h5, 28'h0800000);
		quiet_mode <= 1'b1;
		calc_trigger_pin <= 1'b1;
		repeat (8) @(posedge clock);
		cmp({full_clear, part_clear}, 2'h0);
		quiet_mode <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(4'h5, 28'h0800000 << i);
			calc_trigger_pin <= (i < 2);
			repeat (8) @(posedge clock);
			cmp({full_clear, part_clear}, i % 2 ? 2'h1 : 2'h2);
		end
		output_enable_pin_n <= 1'b1;
		repeat (8) @(posedge clock);
		cmp({full_clear, part_clear}, 2'h0);
		mode_sel <= 2'h0;
		wr(4'h5, 28'h8000000);
		for (int f = 0; f < 3; f++) begin
			rearm_period_field <= 8'(f);
			repeat (4) @(posedge clock);
			cmp(external_rearm, f == 1);
		end
		mode_sel <= 2'h1;
		wr(4'h5, 28'h0600000);
		cmp({stop_inputs_enable, begin_input_enable}, 2'h1);
		begin_pulse <= 1'b1;
		@(posedge clock);
		begin_pulse <= 1'b0;
		repeat (4) @(posedge clock);
		cmp({stop_inputs_enable, begin_input_enable}, 2'h2);
		mode_sel <= 2'h0;
		repeat (4) @(posedge clock);
		cmp(begin_input_enable, 1'b1);
		wr(4'hE, 28'h0000010);
		cmp(half_width_bus_select, 1'b1);
		wr(4'h7, {12'h000, PLL_V[15:0]});
		wr(4'h7, {16'h0000, PLL_V[27:16]});
		cmp({measure_window_timer, pll_loop_open, pll_phase_invert, resolution_regulation_on,
			pll_ref_divider, pll_fast_divider}, {PLL_V[27:15], PLL_V[13:0]});
		rd_chk(4'h7, {12'h000, PLL_V[15:0]});
		rd_chk(4'h7, {16'h0000, PLL_V[27:16]});
		finish_test();
	end
endmodule
